// [hdl/sdiss_top.sv]
// output source selection, gray hold sequencing, overlay and status output
// assumes validity and contact pins are asynchronous; format codes and
// frame_start come from logic on the same clock
`default_nettype none

module sdiss_top #(
    parameter int unsigned SECOND_CYCLES = sdiss_pkg::SECOND_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // configuration settings
    input wire logic input_source_select,
    input wire logic format_locked,
    input wire logic [2:0] gray_hold_seconds,
    input wire logic overlay_on,
    input wire logic reference_only,
    input wire logic [1:0] status_mode,
    input wire logic contact_enable,
    // input side
    input wire logic coax_valid,
    input wire logic optical_valid,
    input wire logic [sdiss_pkg::FMT_W-1:0] coax_format,
    input wire logic [sdiss_pkg::FMT_W-1:0] optical_format,
    input wire logic contact_in,
    input wire logic frame_start,
    // output side
    output logic pass_through,
    output logic gen_active,
    output logic [1:0] picture_sel,
    output logic [sdiss_pkg::FMT_W-1:0] gen_format,
    output logic overlay_en,
    output logic [10:0] box_x,
    output logic [10:0] box_y,
    output logic status_out,
    output logic contact_level
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // travel limit of the box along one axis for the current format
    function automatic logic [10:0] span(input logic is1080,
                                         input logic horiz);
        logic [10:0] size;
        size = horiz ? (is1080 ? sdiss_pkg::WIDTH_1080 : sdiss_pkg::WIDTH_720)
                     : (is1080 ? sdiss_pkg::HEIGHT_1080
                               : sdiss_pkg::HEIGHT_720);
        return size - sdiss_pkg::BOX_SIZE;
    endfunction

    // one pixel step with a bounce at either end, returns {dir, pos}
    function automatic logic [11:0] bounce(input logic [10:0] pos,
                                           input logic dir,
                                           input logic [10:0] limit);
        logic [11:0] r;
        r = {dir, pos};
        if (dir) begin
            r = (pos >= limit) ? {1'b0, pos - 11'h001} : {1'b1, pos + 11'h001};
        end else begin
            r = (pos == 11'h000) ? {1'b1, pos + 11'h001}
                                 : {1'b0, pos - 11'h001};
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers: coax valid, optical valid, contact
    // ------------------------------------------------------------------
    logic [2:0] sync1_reg, sync2_reg, sync3_reg, stable_reg;
    logic [2:0] stable_next;

    // a bit only changes once the second and third stage agree
    always_comb begin
        stable_next = stable_reg;
        for (int i = 0; i < 3; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
                stable_next[i] = sync3_reg[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
            stable_reg <= 3'h0;
        end else begin
            sync1_reg <= {contact_in, optical_valid, coax_valid};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            stable_reg <= stable_next;
        end
    end

    // ------------------------------------------------------------------
    // settings, taken only at a frame boundary
    // ------------------------------------------------------------------
    logic in_sel_reg, locked_reg, ovl_on_reg, ref_only_reg, contact_en_reg;
    logic [2:0] hold_reg;
    logic [1:0] stat_mode_reg;
    logic in_sel_next, locked_next, ovl_on_next, ref_only_next;
    logic contact_en_next;
    logic [2:0] hold_next;
    logic [1:0] stat_mode_next;

    // switching mid-frame would tear the picture, so wait for the boundary
    always_comb begin
        in_sel_next = in_sel_reg;
        locked_next = locked_reg;
        ovl_on_next = ovl_on_reg;
        ref_only_next = ref_only_reg;
        contact_en_next = contact_en_reg;
        hold_next = hold_reg;
        stat_mode_next = stat_mode_reg;
        if (frame_start) begin
            in_sel_next = input_source_select;
            locked_next = format_locked;
            ovl_on_next = overlay_on;
            ref_only_next = reference_only;
            contact_en_next = contact_enable;
            hold_next = gray_hold_seconds;
            stat_mode_next = status_mode;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_sel_reg <= 1'b0;
            locked_reg <= 1'b0;
            ovl_on_reg <= 1'b0;
            ref_only_reg <= 1'b0;
            contact_en_reg <= 1'b0;
            hold_reg <= sdiss_pkg::RST_HOLD;
            stat_mode_reg <= sdiss_pkg::STAT_DISABLED;
        end else begin
            in_sel_reg <= in_sel_next;
            locked_reg <= locked_next;
            ovl_on_reg <= ovl_on_next;
            ref_only_reg <= ref_only_next;
            contact_en_reg <= contact_en_next;
            hold_reg <= hold_next;
            stat_mode_reg <= stat_mode_next;
        end
    end

    // the other connector is never looked at
    logic sel_valid;
    logic [sdiss_pkg::FMT_W-1:0] sel_format;
    assign sel_valid = in_sel_reg ? stable_reg[1] : stable_reg[0];
    assign sel_format = in_sel_reg ? optical_format : coax_format;

    // ------------------------------------------------------------------
    // source sequencing: pass, gray hold, stored image
    // ------------------------------------------------------------------
    sdiss_pkg::sdiss_state_e state_reg, state_next;
    logic [sdiss_pkg::SEC_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic [2:0] sec_cnt_reg, sec_cnt_next;
    logic [1:0] pic_reg, pic_next;
    logic sec_tick;

    assign sec_tick =
        (tick_cnt_reg == sdiss_pkg::SEC_CNT_W'(SECOND_CYCLES - 1));

    always_comb begin
        state_next = state_reg;
        tick_cnt_next = '0;
        sec_cnt_next = 3'h0;
        case (state_reg)
            sdiss_pkg::SDISS_PASS: begin
                if (ref_only_reg) begin
                    state_next = sdiss_pkg::SDISS_STORED;
                end else if (!sel_valid) begin
                    state_next = (hold_reg == 3'h0) ?
                        sdiss_pkg::SDISS_STORED :
                        sdiss_pkg::SDISS_GRAY;
                end
            end
            sdiss_pkg::SDISS_GRAY: begin
                tick_cnt_next = sec_tick ? '0 : tick_cnt_reg + 1'b1;
                sec_cnt_next = sec_cnt_reg + {2'h0, sec_tick};
                if (sel_valid && !ref_only_reg) begin
                    state_next = sdiss_pkg::SDISS_PASS;
                end else if (sec_tick &&
                             (sec_cnt_reg + 3'h1 >= hold_reg)) begin
                    state_next = sdiss_pkg::SDISS_STORED;
                end
            end
            sdiss_pkg::SDISS_STORED: begin
                if (sel_valid && !ref_only_reg) begin
                    state_next = sdiss_pkg::SDISS_PASS;
                end
            end
            default: state_next = sdiss_pkg::SDISS_PASS;
        endcase
        case (state_next)
            sdiss_pkg::SDISS_PASS: pic_next = sdiss_pkg::PIC_PASS;
            sdiss_pkg::SDISS_GRAY: pic_next = sdiss_pkg::PIC_GRAY;
            default: pic_next = sdiss_pkg::PIC_STORED;
        endcase
    end

    // reset lands in pass, which falls to stored one cycle later, the reset hold being zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= sdiss_pkg::SDISS_PASS;
            tick_cnt_reg <= '0;
            sec_cnt_reg <= 3'h0;
            pic_reg <= sdiss_pkg::PIC_PASS;
        end else begin
            state_reg <= state_next;
            tick_cnt_reg <= tick_cnt_next;
            sec_cnt_reg <= sec_cnt_next;
            pic_reg <= pic_next;
        end
    end

    // ------------------------------------------------------------------
    // generator format, status output, contact
    // ------------------------------------------------------------------
    logic [sdiss_pkg::FMT_W-1:0] fmt_reg, fmt_next;
    logic status_reg, status_next, contact_reg, contact_next;

    always_comb begin
        fmt_next = fmt_reg;
        if (!locked_reg && sel_valid) begin
            fmt_next = sel_format;
        end
        case (stat_mode_reg)
            sdiss_pkg::STAT_ON_LOCK: status_next = sel_valid;
            sdiss_pkg::STAT_ON_LOSS: status_next = !sel_valid;
            default: status_next = 1'b0;
        endcase
        // no contact function exists yet; when disabled it is masked
        contact_next = contact_en_reg & stable_reg[2];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fmt_reg <= sdiss_pkg::RST_FORMAT;
            status_reg <= 1'b0;
            contact_reg <= 1'b0;
        end else begin
            fmt_reg <= fmt_next;
            status_reg <= status_next;
            contact_reg <= contact_next;
        end
    end

    // ------------------------------------------------------------------
    // moving overlay box
    // ------------------------------------------------------------------
    logic [10:0] x_reg, y_reg, x_next, y_next;
    logic dx_reg, dy_reg, dx_next, dy_next, ovl_reg, ovl_next;
    logic is1080;
    assign is1080 = fmt_reg[sdiss_pkg::FMT_1080_BIT];

    // one pixel per frame keeps the motion slow but visibly live
    always_comb begin
        {dx_next, x_next} = {dx_reg, x_reg};
        {dy_next, y_next} = {dy_reg, y_reg};
        ovl_next = ovl_on_next && (state_next == sdiss_pkg::SDISS_STORED);
        if (frame_start && ovl_reg) begin
            {dx_next, x_next} = bounce(x_reg, dx_reg, span(is1080, 1'b1));
            {dy_next, y_next} = bounce(y_reg, dy_reg, span(is1080, 1'b0));
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            x_reg <= sdiss_pkg::RST_POS;
            y_reg <= sdiss_pkg::RST_POS;
            dx_reg <= 1'b1;
            dy_reg <= 1'b1;
            ovl_reg <= 1'b0;
        end else begin
            x_reg <= x_next;
            y_reg <= y_next;
            dx_reg <= dx_next;
            dy_reg <= dy_next;
            ovl_reg <= ovl_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign pass_through = (pic_reg == sdiss_pkg::PIC_PASS);
    assign gen_active = !pass_through;
    assign picture_sel = pic_reg;
    assign gen_format = fmt_reg;
    assign overlay_en = ovl_reg;
    assign box_x = x_reg;
    assign box_y = y_reg;
    assign status_out = status_reg;
    assign contact_level = contact_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence loss_in_pass;
        state_reg == sdiss_pkg::SDISS_PASS && !sel_valid && !ref_only_reg;
    endsequence

    chk_pass_valid: assert property (
        sel_valid && !ref_only_reg |=> pass_through && !gen_active)
        else $error("valid input not passed through");
    chk_ref_only: assert property (
        ref_only_reg && $past(ref_only_reg) |=> !pass_through)
        else $error("pass-through in reference-only mode");
    chk_zero_hold: assert property (
        loss_in_pass ##0 (hold_reg == 3'h0) |=>
        picture_sel == sdiss_pkg::PIC_STORED)
        else $error("zero hold did not go straight to stored image");
    chk_gray_entry: assert property (
        loss_in_pass ##0 (hold_reg != 3'h0) |=>
        picture_sel == sdiss_pkg::PIC_GRAY)
        else $error("loss did not start gray hold");
    chk_gray_expiry: assert property (
        state_reg == sdiss_pkg::SDISS_GRAY && sec_tick && !sel_valid &&
        sec_cnt_reg + 3'h1 == hold_reg |=>
        picture_sel == sdiss_pkg::PIC_STORED)
        else $error("hold expiry did not show stored image");
    chk_status_lock: assert property (
        stat_mode_reg == sdiss_pkg::STAT_ON_LOCK |=>
        status_out == $past(sel_valid))
        else $error("status does not follow lock");
    chk_status_loss: assert property (
        stat_mode_reg == sdiss_pkg::STAT_ON_LOSS |=>
        status_out == !$past(sel_valid))
        else $error("status does not follow loss");
    chk_status_off: assert property (
        stat_mode_reg == sdiss_pkg::STAT_DISABLED |=> !status_out)
        else $error("disabled status output active");
    chk_contact_mask: assert property (
        !contact_en_reg |=> !contact_level)
        else $error("disabled contact reached output");
    chk_overlay_gate: assert property (
        overlay_en |-> picture_sel == sdiss_pkg::PIC_STORED && ovl_on_reg)
        else $error("overlay outside stored image");
    chk_format_hold: assert property (
        locked_reg |=> $stable(gen_format))
        else $error("locked format changed");
    chk_frame_apply: assert property (
        !frame_start |=> $stable(hold_reg) && $stable(ref_only_reg))
        else $error("setting changed off frame boundary");
endmodule

`default_nettype wire

// [shared/sdiss_pkg.sv]
// constants, types and reset values for the sdi output source select block
// assumes a single 20 MHz system clock shared by every user of this package
`default_nettype none

package sdiss_pkg;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam longint unsigned ONE_SECOND_NS = 64'h0000_0000_3b9a_ca00;
    // a second is a longest time here, so integer division rounds down
    localparam int unsigned SECOND_CYCLES =
        int'(ONE_SECOND_NS / longint'(CLK_PERIOD_NS));
    localparam int unsigned SEC_CNT_W = 25;

    // ------------------------------------------------------------------
    // source state, picture codes, status modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SDISS_PASS   = 2'h0,
        SDISS_GRAY   = 2'h1,
        SDISS_STORED = 2'h3
    } sdiss_state_e;

    localparam logic [1:0] PIC_PASS = 2'h0;
    localparam logic [1:0] PIC_GRAY = 2'h1;
    localparam logic [1:0] PIC_STORED = 2'h2;

    typedef enum logic [1:0] {
        STAT_DISABLED = 2'h0,
        STAT_ON_LOCK  = 2'h1,
        STAT_ON_LOSS  = 2'h2
    } sdiss_status_e;

    // ------------------------------------------------------------------
    // format code and overlay geometry
    // ------------------------------------------------------------------
    localparam int unsigned FMT_W = 4;
    localparam int unsigned FMT_1080_BIT = 3;
    localparam logic [10:0] BOX_SIZE = 11'h040;
    localparam logic [10:0] WIDTH_720 = 11'h500;
    localparam logic [10:0] HEIGHT_720 = 11'h2d0;
    localparam logic [10:0] WIDTH_1080 = 11'h780;
    localparam logic [10:0] HEIGHT_1080 = 11'h438;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_HOLD = 3'h0;
    localparam logic [FMT_W-1:0] RST_FORMAT = 4'h0;
    localparam logic [10:0] RST_POS = 11'h000;
endpackage

`default_nettype wire

// [sim/sdiss_src_model.sv]
// upstream source model: connector validity, format codes, frame pulses
// assumes the bench drives the on and code controls on the rising edge
`default_nettype none

module sdiss_src_model #(
    parameter int unsigned FRAME_CYCLES = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bench controls
    input wire logic coax_on,
    input wire logic optical_on,
    input wire logic [sdiss_pkg::FMT_W-1:0] coax_code,
    input wire logic [sdiss_pkg::FMT_W-1:0] optical_code,
    // toward the block
    output logic coax_valid,
    output logic optical_valid,
    output logic [sdiss_pkg::FMT_W-1:0] coax_format,
    output logic [sdiss_pkg::FMT_W-1:0] optical_format,
    output logic frame_start
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // frame timing and junk pattern
    // ------------------------------------------------------------------
    logic [7:0] cnt_reg;
    logic [sdiss_pkg::FMT_W-1:0] pat_reg;

    // frames run free, the block owns no frame timing of its own
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            pat_reg <= 4'h0;
        end else begin
            cnt_reg <= (cnt_reg == 8'(FRAME_CYCLES - 1)) ? 8'h00
                                                         : cnt_reg + 8'h01;
            pat_reg <= pat_reg + 4'h5;
        end
    end

    // a dead connector shows a changing code, not held at its last good one
    assign frame_start = (cnt_reg == 8'h00) && rst_n;
    assign coax_valid = coax_on;
    assign optical_valid = optical_on;
    assign coax_format = coax_on ? coax_code : pat_reg;
    assign optical_format = optical_on ? optical_code : ~pat_reg;
endmodule

`default_nettype wire

// [sim/sdiss_top_tb.sv]
// self-checking bench for the output source select block
// assumes the source model supplies validity, formats and frame pulses
`default_nettype none

module sdiss_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int SC = 20;
    typedef struct {
        logic [1:0] mode; logic sel, cv, ov, rf, ovl;
        logic pass; logic [1:0] pic; logic stat, oven;
    } sdiss_row_s;
    logic clock = 1'b0, rst_n = 1'b0;
    logic input_source_select = 1'b0, format_locked = 1'b0;
    logic [2:0] gray_hold_seconds = 3'h0;
    logic overlay_on = 1'b0, reference_only = 1'b0, contact_enable = 1'b0;
    logic [1:0] status_mode = 2'h0;
    logic coax_on = 1'b0, optical_on = 1'b0, contact_in = 1'b0;
    logic [3:0] coax_code = 4'h0, optical_code = 4'h0;
    logic coax_valid, optical_valid, frame_start;
    logic [3:0] coax_format, optical_format, gen_format;
    logic pass_through, gen_active, overlay_en, status_out, contact_level;
    logic [1:0] picture_sel;
    logic [10:0] box_x, box_y, bx, by;
    int fail_count = 0, n_tests = 0, cycles = 0, k;
    sdiss_row_s rows [7];

    initial begin
        forever #25 clock = ~clock;
    end

    sdiss_src_model #(.FRAME_CYCLES(32)) src (.clock(clock), .rst_n(rst_n),
        .coax_on(coax_on), .optical_on(optical_on), .coax_code(coax_code),
        .optical_code(optical_code), .coax_valid(coax_valid),
        .optical_valid(optical_valid), .coax_format(coax_format),
        .optical_format(optical_format), .frame_start(frame_start));

    sdiss_top #(.SECOND_CYCLES(SC)) dut (.clock(clock), .rst_n(rst_n),
        .input_source_select(input_source_select),
        .format_locked(format_locked), .gray_hold_seconds(gray_hold_seconds),
        .overlay_on(overlay_on), .reference_only(reference_only),
        .status_mode(status_mode), .contact_enable(contact_enable),
        .coax_valid(coax_valid), .optical_valid(optical_valid),
        .coax_format(coax_format), .optical_format(optical_format),
        .contact_in(contact_in), .frame_start(frame_start),
        .pass_through(pass_through), .gen_active(gen_active),
        .picture_sel(picture_sel), .gen_format(gen_format),
        .overlay_en(overlay_en), .box_x(box_x), .box_y(box_y),
        .status_out(status_out), .contact_level(contact_level));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [10:0] got, input logic [10:0] exp,
                         input string msg);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // settings only land on a frame pulse, so wait one out, then settle;
    // step off the edge first so the old pulse is not mistaken for a new one
    task automatic frame_settle(input int n);
        #1;
        for (k = 0; k < 100 && frame_start !== 1'b1; k++) @(posedge clock) #1;
        repeat (n + 1) @(posedge clock);
        #1;
    endtask

    // hang guard, covers the slowest hold plus every frame wait
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rows[0] = '{2'h1, 0, 1, 0, 0, 0, 1, 2'h0, 1, 0};
        rows[1] = '{2'h1, 1, 1, 0, 0, 1, 0, 2'h2, 0, 1};
        rows[2] = '{2'h2, 1, 0, 1, 0, 1, 1, 2'h0, 0, 0};
        rows[3] = '{2'h2, 0, 0, 1, 0, 0, 0, 2'h2, 1, 0};
        rows[4] = '{2'h0, 0, 1, 0, 0, 0, 1, 2'h0, 0, 0};
        rows[5] = '{2'h3, 0, 0, 0, 0, 0, 0, 2'h2, 0, 0};
        rows[6] = '{2'h1, 0, 1, 0, 1, 1, 0, 2'h2, 1, 1};
        repeat (15) @(posedge clock);
        #1;
        check(pass_through, 1, "reset pass");
        check(picture_sel, 0, "reset picture");
        check(status_out, 0, "reset status");
        check(box_x, 0, "reset box");
        @(posedge clock) rst_n <= 1'b1;
        // table of mode, connector and status cases, hold zero
        foreach (rows[i]) begin
            @(posedge clock);
            status_mode <= rows[i].mode;
            input_source_select <= rows[i].sel;
            coax_on <= rows[i].cv;
            optical_on <= rows[i].ov;
            reference_only <= rows[i].rf;
            overlay_on <= rows[i].ovl;
            frame_settle(8);
            check(pass_through, rows[i].pass, "pass");
            check(gen_active, !rows[i].pass, "gen idle");
            check(picture_sel, rows[i].pic, "picture");
            check(status_out, rows[i].stat, "status");
            check(overlay_en, rows[i].oven, "overlay");
        end
        // moving box: one pixel per frame on both axes
        bx = box_x;
        by = box_y;
        frame_settle(2);
        check(box_x, bx + 11'h001, "box x step");
        check(box_y, by + 11'h001, "box y step");
        // gray hold of two seconds after loss
        @(posedge clock);
        reference_only <= 1'b0;
        overlay_on <= 1'b0;
        gray_hold_seconds <= 3'h2;
        frame_settle(8);
        check(pass_through, 1, "pass before loss");
        @(posedge clock) coax_on <= 1'b0;
        for (k = 0; k < 12 && picture_sel !== 2'h1; k++) @(posedge clock) #1;
        check(picture_sel, 1, "gray entered");
        bx = 0;
        while (picture_sel === 2'h1 && bx < 200) begin
            @(posedge clock) #1;
            bx++;
        end
        check(picture_sel, 2, "stored after hold");
        check(bx >= 2 * SC - 1 && bx <= 2 * SC + 1, 1, "hold length");
        // return of input in mid gray goes straight to pass
        @(posedge clock) gray_hold_seconds <= 3'h7;
        frame_settle(1);
        @(posedge clock) coax_on <= 1'b1;
        repeat (8) @(posedge clock);
        @(posedge clock) coax_on <= 1'b0;
        repeat (15) @(posedge clock);
        #1;
        check(picture_sel, 1, "seven second gray");
        @(posedge clock) coax_on <= 1'b1;
        repeat (7) @(posedge clock);
        #1;
        check(picture_sel, 0, "immediate return");
        // format follows in auto, freezes when locked
        @(posedge clock) coax_code <= 4'h9;
        frame_settle(3);
        check(gen_format, 4'h9, "auto format");
        @(posedge clock) format_locked <= 1'b1;
        frame_settle(1);
        @(posedge clock) coax_code <= 4'h3;
        frame_settle(3);
        check(gen_format, 4'h9, "locked format");
        // mid-frame setting change waits for the frame boundary
        @(posedge clock) status_mode <= 2'h2;
        repeat (8) @(posedge clock);
        #1;
        check(status_out, 1, "setting held off");
        frame_settle(3);
        check(status_out, 0, "setting applied");
        // contact masked while disabled
        @(posedge clock) contact_in <= 1'b1;
        frame_settle(6);
        check(contact_level, 0, "contact masked");
        @(posedge clock) contact_enable <= 1'b1;
        frame_settle(6);
        check(contact_level, 1, "contact enabled");
        final_report();
    end
endmodule

`default_nettype wire
